// >>> hdl/call_test_pkg.sv
// Purpose: shared constants for the call release and test character block
// Assumes: 100 MHz core clock
// Notes: long counts are defaults for top-level parameters
package call_test_pkg;
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 10;
	// on-hook timeout, in seconds
	localparam int unsigned ONHOOK_S       = 15;
	localparam longint unsigned ONHOOK_CYCLES_L =
		longint'(ONHOOK_S) * longint'(CLK_HZ);
	localparam logic [31:0] ONHOOK_CYCLES  = ONHOOK_CYCLES_L[31:0];
	// least stretched strobe pulse width, in ns (rounded up)
	localparam int unsigned TCA_MIN_NS     = 30_000;
	localparam logic [15:0] TCA_CYCLES     =
		16'((TCA_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// button noise filter interval, in us
	localparam int unsigned FILTER_US      = 10;
	localparam logic [31:0] FILTER_CYCLES  =
		32'(FILTER_US * (CLK_HZ / 1_000_000));
	// test oscillator period, in us (one character time)
	localparam int unsigned TEST_OSC_US    = 8_000;
	localparam logic [31:0] TEST_OSC_CYCLES =
		32'(TEST_OSC_US * (CLK_HZ / 1_000_000));
	localparam int unsigned DATA_W         = 8;
	localparam int unsigned STRAP_W        = 7;
	localparam int unsigned FIFO_DEPTH     = 16;
	// fifo word: source flag above the character
	localparam int unsigned WORD_W         = DATA_W + 1;
	localparam int unsigned SRC_BIT        = DATA_W;
	localparam logic [31:0] CNT_ZERO       = 32'h0000_0000;
	localparam logic [15:0] PULSE_ZERO     = 16'h0000;
	typedef enum logic [0:0] {
		HANG_IDLE,
		HANG_EXPIRED
	} hang_state_type;
endpackage

// >>> hdl/call_test_ctrl.sv
// Purpose: call release timer and test character generator for printer
// Assumes: inputs synchronous to core_clk; power-on reset via rst_n
// Notes: one fifo of 16 characters feeds the printer strobe;
//        words carry a source flag so stale ones can be dropped;
//        a line character held at test start is lost, as if blinded;
//        timer and filter spans are parameters, shortened in the bench
`timescale 1ns/100ps

module char_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	// pointers wrap on their own since depth is a power of two
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return p + 1'b1;
	endfunction

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0]   count;
	} fifo_state_type;

	fifo_state_type   s_q;
	fifo_state_type   s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;
	logic             full;
	logic             empty;

	// full and empty come straight from the count, never from pointers
	assign full      = (s_q.count == (AW+1)'(DEPTH));
	assign empty     = (s_q.count == '0);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[s_q.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		s_d = s_q;
		if (push)
			s_d.wr_ptr = bump(s_q.wr_ptr);
		if (pop)
			s_d.rd_ptr = bump(s_q.rd_ptr);
		if (push && !pop)
			s_d.count = s_q.count + 1'b1;
		else if (pop && !push)
			s_d.count = s_q.count - 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// storage needs no reset; count guards every read
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[s_q.wr_ptr] <= in_data;
	end
endmodule

module call_test_ctrl #(
	parameter logic [31:0] ONHOOK_CNT = call_test_pkg::ONHOOK_CYCLES,
	parameter logic [31:0] FILTER_CNT = call_test_pkg::FILTER_CYCLES,
	parameter logic [31:0] OSC_CNT    = call_test_pkg::TEST_OSC_CYCLES
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       carrier_detect,
	input  wire logic       call_connected_input,
	output logic            data_terminal_ready,
	input  wire logic       test_button,
	input  wire logic [6:0] test_straps,
	input  wire logic       line_valid,
	output logic            line_ready,
	input  wire logic [7:0] line_data,
	input  wire logic       printer_ready,
	output logic            char_avail,
	output logic      [7:0] data_out,
	output logic            test_receive_message,
	output logic            ca_stop,
	output logic            blind
);
	// all control state lives in one record, registered once below
	typedef struct packed {
		call_test_pkg::hang_state_type hang;
		logic [31:0]                   hang_cnt;
		logic                          test_active;
		logic [31:0]                   filt_cnt;
		logic [31:0]                   osc_cnt;
		logic                          tick_pend;
		logic [15:0]                   pulse_cnt;
		logic [7:0]                    data;
		logic                          strobe_test;
	} ctrl_state_type;

	ctrl_state_type s_q;
	ctrl_state_type s_d;

	logic                                 fifo_in_valid;
	logic                                 fifo_in_ready;
	logic [call_test_pkg::WORD_W-1:0]     fifo_in_data;
	logic                                 fifo_out_valid;
	logic                                 fifo_out_ready;
	logic [call_test_pkg::WORD_W-1:0]     fifo_out_data;
	logic                                 osc_tick;
	logic                                 test_push;
	logic                                 out_is_test;
	logic                                 strobe_start;
	logic                                 last_test;

	function automatic logic [31:0] count_up(input logic [31:0] c);
		return c + 32'h0000_0001;
	endfunction

	// a span counter sits on its final cycle
	function automatic logic at_last(input logic [31:0] c,
		input logic [31:0] lim);
		return c == lim - 32'h0000_0001;
	endfunction

	// a fifo word may reach the printer only in its own mode
	function automatic logic src_match(input logic is_test,
		input logic active);
		return is_test == active;
	endfunction

	char_fifo #(
		.WIDTH (call_test_pkg::WORD_W),
		.DEPTH (call_test_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	assign osc_tick    = at_last(s_q.osc_cnt, OSC_CNT);
	// a held tick waits for fifo room rather than being lost
	assign test_push   = s_q.test_active && (osc_tick || s_q.tick_pend);
	assign out_is_test = fifo_out_data[call_test_pkg::SRC_BIT];
	assign strobe_start = fifo_out_ready && fifo_out_valid
		&& src_match(out_is_test, s_q.test_active);
	// the test flop lets go as the final test strobe ends
	assign last_test   = s_q.test_active && s_q.strobe_test
		&& (s_q.pulse_cnt == 16'h0001);

	always_comb
	begin
		line_ready   = fifo_in_ready && !s_q.test_active;
		fifo_in_valid = test_push || (line_valid && line_ready);
		if (test_push)
			fifo_in_data = {1'b1, 1'b0, test_straps};
		else
			fifo_in_data = {1'b0, line_data};
	end

	// drain: a word of the other mode is dropped without a strobe;
	// a queued line word left waiting would wedge test words behind it
	always_comb
	begin
		fifo_out_ready = 1'b0;
		if (fifo_out_valid && s_q.pulse_cnt == call_test_pkg::PULSE_ZERO)
		begin
			if (out_is_test && !s_q.test_active)
				fifo_out_ready = 1'b1;
			else if (!src_match(out_is_test, s_q.test_active))
				fifo_out_ready = 1'b1;
			else
				fifo_out_ready = printer_ready;
		end
	end

	always_comb
	begin
		s_d = s_q;

		// call release
		// carrier back or call gone restarts the span from zero
		case (s_q.hang)
			call_test_pkg::HANG_IDLE:
			begin
				if (call_connected_input && !carrier_detect)
				begin
					s_d.hang_cnt = count_up(s_q.hang_cnt);
					if (at_last(s_q.hang_cnt, ONHOOK_CNT))
						s_d.hang = call_test_pkg::HANG_EXPIRED;
				end
				else
					s_d.hang_cnt = call_test_pkg::CNT_ZERO;
			end
			call_test_pkg::HANG_EXPIRED:
			begin
				// data set answers a dropped terminal ready by hanging up
				if (!call_connected_input)
				begin
					s_d.hang     = call_test_pkg::HANG_IDLE;
					s_d.hang_cnt = call_test_pkg::CNT_ZERO;
				end
			end
			default:
			begin
				s_d.hang     = call_test_pkg::HANG_IDLE;
				s_d.hang_cnt = call_test_pkg::CNT_ZERO;
			end
		endcase

		// button filter: any release restarts the interval
		if (!test_button)
			s_d.filt_cnt = call_test_pkg::CNT_ZERO;
		else if (s_q.filt_cnt != FILTER_CNT)
			s_d.filt_cnt = count_up(s_q.filt_cnt);

		// free-running oscillator
		if (osc_tick)
			s_d.osc_cnt = call_test_pkg::CNT_ZERO;
		else
			s_d.osc_cnt = count_up(s_q.osc_cnt);

		// a tick met by a full fifo is kept, set winning over the clear
		if (s_q.test_active && osc_tick && !fifo_in_ready)
			s_d.tick_pend = 1'b1;
		else if (fifo_in_ready || !s_q.test_active)
			s_d.tick_pend = 1'b0;

		// test flop: a filtered press sets it; once released, the end
		// of the next test strobe clears it and gates the straps off
		if (test_button && s_q.filt_cnt == FILTER_CNT)
			s_d.test_active = 1'b1;
		else if (!test_button && last_test)
		begin
			s_d.test_active = 1'b0;
			s_d.data        = 8'h00;
		end

		// strobe stretch and output data
		if (s_q.pulse_cnt != call_test_pkg::PULSE_ZERO)
			s_d.pulse_cnt = s_q.pulse_cnt - 16'h0001;
		if (strobe_start)
		begin
			s_d.pulse_cnt = call_test_pkg::TCA_CYCLES;
			s_d.data      = fifo_out_data[7:0];
			s_d.strobe_test = out_is_test;
		end
	end

	always_ff @(posedge core_clk)
	begin
		// hang state resets to idle, so terminal ready is up at once
		if (!rst_n)
		begin
			s_q      <= '0;
			s_q.hang <= call_test_pkg::HANG_IDLE;
		end
		else
			s_q <= s_d;
	end

	// every output below comes from registers only: plain copies, or compares for ready and strobe
	assign data_terminal_ready  = (s_q.hang == call_test_pkg::HANG_IDLE);
	assign char_avail           = (s_q.pulse_cnt != call_test_pkg::PULSE_ZERO);
	assign data_out             = s_q.data;
	assign test_receive_message = s_q.test_active;
	assign ca_stop              = s_q.test_active;
	assign blind                = s_q.test_active;
endmodule

// >>> bench/call_test_ctrl_sva.sv
// Purpose: port assertions for call_test_ctrl
// Assumes: one clock domain, reset low synchronous
// Notes: width counter keeps the 3000 cycle check cheap
`timescale 1ns/100ps
module call_test_ctrl_sva (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       carrier_detect,
	input wire logic       call_connected_input,
	input wire logic       data_terminal_ready,
	input wire logic       test_button,
	input wire logic [6:0] test_straps,
	input wire logic       line_ready,
	input wire logic       char_avail,
	input wire logic [7:0] data_out,
	input wire logic       test_receive_message,
	input wire logic       ca_stop,
	input wire logic       blind
);
	logic [15:0] high_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !char_avail)
			high_q <= 16'h0000;
		else
			high_q <= high_q + 16'h0001;
	end
	a_stop_test: assert property (
		ca_stop == test_receive_message)
		else $error("stop differs from test state");
	a_blind_refuse: assert property (
		blind |-> !line_ready)
		else $error("line accepted while blind");
	a_test_char: assert property (
		$rose(char_avail) && test_receive_message
		|-> data_out == {1'h0, test_straps})
		else $error("test character wrong");
	a_dtr_back: assert property (
		!data_terminal_ready && !call_connected_input
		|=> data_terminal_ready)
		else $error("ready not restored");
	a_dtr_cause: assert property (
		$fell(data_terminal_ready) |-> !$past(carrier_detect))
		else $error("ready dropped with carrier");
	a_tca_width: assert property (
		$fell(char_avail) |-> high_q >= call_test_pkg::TCA_CYCLES)
		else $error("strobe too short");
	a_release_hold: assert property (
		$fell(test_receive_message) |-> !$past(test_button))
		else $error("test ended with button held");
	a_button_filter: assert property (
		$rose(test_receive_message)
		|-> $past(test_button, 2) && $past(test_button, 3))
		else $error("test set by short press");
endmodule
bind call_test_ctrl call_test_ctrl_sva u_sva (.core_clk, .rst_n,
	.carrier_detect, .call_connected_input, .data_terminal_ready,
	.test_button, .test_straps, .line_ready, .char_avail, .data_out,
	.test_receive_message, .ca_stop, .blind);

// >>> bench/far_side_model.sv
// Purpose: data set and printer stand-in
// Assumes: bench pulses call_req to answer a call
// Notes: call stays up until ready is withdrawn
`timescale 1ns/100ps
module far_side_model (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic dtr,
	input  wire logic call_req,
	input  wire logic stall,
	output logic      call_up,
	output logic      prn_ready
);
	assign prn_ready = !stall;
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !dtr)
			call_up <= 1'h0;
		else if (call_req)
			call_up <= 1'h1;
	end
endmodule

// >>> bench/tb_call_test_ctrl.sv
// Purpose: self-checking bench for call_test_ctrl
// Assumes: shortened counts, inputs driven on falling edge
// Notes: one task per scenario
`timescale 1ns/100ps
module tb_call_test_ctrl;
	localparam logic [6:0] STRAPS = 7'h57;
	logic       core_clk = 0;
	logic       rst_n = 0;
	logic       carrier = 0;
	logic       call_req = 0;
	logic       stall = 0;
	logic       button = 0;
	logic       valid = 0;
	logic [7:0] ldata = 8'h00;
	logic       conn, dtr, lready, prdy, ca, trm, stop, blind;
	logic [7:0] dout;
	int         err_total = 0;
	int         tests_run = 0;
	int         n;
	always #5 core_clk = ~core_clk;
	far_side_model u_far (.core_clk, .rst_n, .dtr, .call_req, .stall,
		.call_up(conn), .prn_ready(prdy));
	call_test_ctrl #(.ONHOOK_CNT(32'h0000_00C8), .FILTER_CNT(32'h0000_0004),
		.OSC_CNT(32'h0000_0FA0)) u_dut (.core_clk, .rst_n,
		.carrier_detect(carrier), .call_connected_input(conn),
		.data_terminal_ready(dtr), .test_button(button),
		.test_straps(STRAPS), .line_valid(valid), .line_ready(lready),
		.line_data(ldata), .printer_ready(prdy), .char_avail(ca),
		.data_out(dout), .test_receive_message(trm), .ca_stop(stop),
		.blind);
	task automatic chk(input string nm, input logic [7:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic stop_test();
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim)
		begin
			@(negedge core_clk);
			n++;
		end
	endtask
	task automatic t_hangup();
		call_req = 1;
		carrier = 1;
		cyc(2);
		call_req = 0;
		cyc(300);
		chk("dtr_carrier", dtr, 1'h1);
		carrier = 0;
		cyc(100);
		carrier = 1;
		cyc(2);
		carrier = 0;
		wait_lvl(dtr, 1'h0, 400);
		chk("drop_time", n >= 195 && n <= 205, 1'h1);
		cyc(4);
		chk("dtr_back", dtr, 1'h1);
		chk("call", conn, 1'h0);
	endtask
	task automatic t_fifo();
		stall = 1;
		for (int i = 0; i <= 16; i++)
		begin
			ldata = 8'hA0 + 8'(i);
			valid = 1;
			chk("room", lready, i < 16);
			cyc(1);
		end
		valid = 0;
		stall = 0;
		for (int i = 0; i < 16; i++)
		begin
			wait_lvl(ca, 1'h1, 5000);
			chk("byte", dout, 8'hA0 + 8'(i));
			wait_lvl(ca, 1'h0, 5000);
			chk("width", n >= 2999, 1'h1);
		end
	endtask
	task automatic t_test();
		stall = 1;
		valid = 1;
		cyc(1);
		valid = 0;
		button = 1;
		cyc(3);
		button = 0;
		cyc(10);
		chk("glitch", trm, 1'h0);
		button = 1;
		wait_lvl(trm, 1'h1, 20);
		stall = 0;
		valid = 1;
		chk("stop", stop, 1'h1);
		chk("blind", blind, 1'h1);
		chk("refuse", lready, 1'h0);
		for (int i = 0; i < 2; i++)
		begin
			wait_lvl(ca, 1'h1, 9000);
			chk("tca", ca, 1'h1);
			chk("tchar", dout, {1'h0, STRAPS});
			wait_lvl(ca, 1'h0, 5000);
		end
		chk("repeat", n >= 2999, 1'h1);
		valid = 0;
		button = 0;
		cyc(10);
		chk("hold", trm, 1'h1);
		wait_lvl(ca, 1'h1, 4100);
		chk("last_ca", ca, 1'h1);
		chk("last_trm", trm, 1'h1);
		wait_lvl(trm, 1'h0, 3100);
		chk("end", trm, 1'h0);
		chk("gated", dout, 8'h00);
		cyc(10);
		wait_lvl(ca, 1'h1, 8100);
		chk("idle_osc", ca, 1'h0);
	endtask
	initial
	begin
		cyc(6);
		chk("rst_dtr", dtr, 1'h1);
		chk("rst_test", trm, 1'h0);
		rst_n = 1;
		t_hangup();
		t_fifo();
		t_test();
		stop_test();
	end
	initial
	begin
		cyc(100000);
		err_total++;
		stop_test();
	end
endmodule
